/* hdl/swgc_age_timer.sv */
// aging period timer with link loss fast aging
`timescale 1ns/1ps
module swgc_age_timer
  import swgc_pkg::*;
#(
  parameter logic [35:0] FAST_CYC = 36'(FAST_AGE_CYC),
  parameter logic [35:0] NORM_CYC = 36'(NORM_AGE_CYC)
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // control
  input wire logic link_age_en_i,
  input wire logic [3:0] link_up_i,
  input wire logic age_pass_done_i,
  // to the aging engine
  output logic age_start_o,
  output logic fast_age_o
);

  typedef struct packed {
    logic [3:0] link_q;
    logic [AGE_CNT_W-1:0] cnt;
    logic fast;
    logic start;
  } age_s;

  age_s st_r;
  age_s st_nxt;
  logic link_fall;

  always_comb begin
    st_nxt = st_r;
    st_nxt.link_q = link_up_i;
    st_nxt.start = 1'b0;
    link_fall = |(st_r.link_q & ~link_up_i);
    if (link_age_en_i && link_fall) begin
      // any port lost: age every learned address in one fast pass
      st_nxt.fast = 1'b1; // R8 R10
      st_nxt.start = 1'b1; // R8
      st_nxt.cnt = '0;
    end else if (st_r.fast) begin
      // the pass is cut off at the deadline even if the engine is slow
      if (age_pass_done_i || st_r.cnt == FAST_CYC - 36'h1) begin
        st_nxt.fast = 1'b0; // R9
        st_nxt.cnt = '0;
      end else begin
        st_nxt.cnt = st_r.cnt + 36'h1;
      end
    end else if (st_r.cnt == NORM_CYC - 36'h1) begin
      // nominal period sits inside the allowed tolerance
      st_nxt.cnt = '0; // R9
      st_nxt.start = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 36'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign age_start_o = st_r.start;
  assign fast_age_o = st_r.fast;

endmodule

/* hdl/swgc_pkg.sv */
// constants for the switch global control register pair
package swgc_pkg;

  // register offsets on the management port
  localparam logic [7:0] GC_ZERO_OFS = 8'h02;
  localparam logic [7:0] GC_ONE_OFS = 8'h03;

  // global control zero fields
  localparam int GC0_ALT_BACKOFF_BIT = 7;
  localparam int GC0_RSVD6_BIT = 6;
  localparam int GC0_FLUSH_DYN_BIT = 5;
  localparam int GC0_FLUSH_STA_BIT = 4;
  localparam int GC0_RSVD3_BIT = 3;
  localparam int GC0_RSVD2_BIT = 2;
  localparam int GC0_PAUSE_MODE_BIT = 1;
  localparam int GC0_LINK_AGE_BIT = 0;

  // global control one fields held here
  localparam int GC1_FWD_ERR_BIT = 7;
  localparam int GC1_HUGE_BIT = 6;

  // values after reset
  localparam logic RST_ALT_BACKOFF = 1'b0;
  localparam logic RST_PAUSE_MODE = 1'b0;
  localparam logic RST_LINK_AGE = 1'b0;
  localparam logic RST_FWD_ERR = 1'b0;
  localparam logic RST_HUGE = 1'b0;
  localparam logic [3:0] RST_GC1_LOW = 4'h0;
  // reserved bits of global control zero: 6 reads 0, 3 and 2 read 1
  localparam logic RSVD6_VAL = 1'b0;
  localparam logic RSVD32_VAL = 1'b1;

  // frame filtering
  localparam logic [15:0] PAUSE_TYPE_LEN = 16'h8808;
  localparam logic [47:0] PAUSE_DA = 48'h0180C2000001;
  localparam logic [11:0] HUGE_MAX_LEN = 12'h800;
  localparam logic [11:0] STD_MAX_LEN = 12'h600;

  // address tables
  localparam int NUM_PORTS = 4;
  localparam int TBL_IDX_W = 10;
  localparam logic [9:0] DYN_TBL_LAST = 10'h3FF;
  localparam logic [9:0] STA_TBL_LAST = 10'h01F;

  // aging timing
  localparam longint CLK_HZ = 100_000_000;
  localparam longint FAST_AGE_MAX_US = 800;
  localparam longint NORM_AGE_S = 300;
  localparam longint NORM_AGE_TOL_S = 75;
  localparam longint FAST_AGE_CYC = FAST_AGE_MAX_US * CLK_HZ / 1_000_000;
  localparam longint NORM_AGE_CYC = NORM_AGE_S * CLK_HZ;
  localparam int AGE_CNT_W = 36;

endpackage

/* hdl/swgc_regs.sv */
// switch global control registers zero and one with flush and filters
`timescale 1ns/1ps
// Notes on behaviour
// (R1) bit 7 selects alternate collision back-off
// (R2) writing dynamic flush bit starts learned-entry flush
// (R3) dynamic flush removes entries of learning-off ports
// (R4) writing static flush bit starts static-entry flush
// (R5) static match: unicast, single port, learning off
// (R6) pause mode drops 0x8808 or reserved pause DA
// (R7) pause mode clear drops flow-control frames only
// (R8) link loss starts fast aging under 800us
// (R9) after fast pass return to 300s aging
// (R10) unplugged port ages out all learned addresses
// (R11) forward errored frames bit passes bad frames
// (R12) bit 6 enables frames up to 2K bytes
// (R13) flush bits read one while walk runs
module swgc_regs
  import swgc_pkg::*;
#(
  parameter logic [35:0] FAST_CYC = 36'(FAST_AGE_CYC),
  parameter logic [35:0] NORM_CYC = 36'(NORM_AGE_CYC)
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // management register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // mode outputs to the macs and forwarding logic
  output logic alt_backoff_o,
  output logic pause_filter_mode_o,
  output logic fwd_err_frames_o,
  output logic huge_frame_en_o,
  output logic [3:0] gc1_low_o,
  // per port status
  input wire logic [3:0] learn_dis_i,
  input wire logic [3:0] link_up_i,
  // address table walk
  output logic tbl_rd_o,
  output logic tbl_del_o,
  output logic tbl_static_o,
  output logic [TBL_IDX_W-1:0] tbl_idx_o,
  input wire logic ent_valid_i,
  input wire logic [1:0] ent_port_i,
  input wire logic [3:0] ent_fwd_mask_i,
  input wire logic ent_group_i,
  // aging engine
  input wire logic age_pass_done_i,
  output logic age_start_o,
  output logic fast_age_o,
  // frame check
  input wire logic frm_chk_i,
  input wire logic [15:0] frm_type_len_i,
  input wire logic [47:0] frm_da_i,
  input wire logic frm_fc_i,
  input wire logic frm_bad_i,
  input wire logic [11:0] frm_len_i,
  output logic frm_drop_o,
  output logic frm_drop_v_o
);

  typedef enum logic [1:0] {
    FL_IDLE,
    FL_READ,
    FL_CHECK,
    FL_DEL
  } flush_state_e;

  typedef struct packed {
    logic alt_backoff;
    logic pause_mode;
    logic link_age;
    logic fwd_err;
    logic huge;
    logic [3:0] gc1_low;
    logic dyn_pend;
    logic sta_pend;
    flush_state_e fst;
    logic cur_static;
    logic [TBL_IDX_W-1:0] idx;
    logic [7:0] rdata;
    logic rvalid;
    logic drop;
    logic drop_v;
  } regs_s;

  regs_s st_r;
  regs_s st_nxt;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic one_hot4(input logic [3:0] m);
    one_hot4 = (m != 4'h0) && ((m & (m - 4'h1)) == 4'h0);
  endfunction

  function automatic logic ent_match(input logic is_static,
                                     input logic valid,
                                     input logic [1:0] port,
                                     input logic [3:0] mask,
                                     input logic group,
                                     input logic [3:0] ldis);
    if (!valid) begin
      ent_match = 1'b0;
    end else if (is_static) begin
      ent_match = !group && one_hot4(mask) && ((mask & ldis) != 4'h0); // R5
    end else begin
      ent_match = ldis[port]; // R3
    end
  endfunction

  function automatic logic frame_drop(input logic pmode,
                                      input logic fwd_err,
                                      input logic huge,
                                      input logic [15:0] tl,
                                      input logic [47:0] da,
                                      input logic fc,
                                      input logic bad,
                                      input logic [11:0] len);
    logic pause_hit;
    logic too_long;
    pause_hit = pmode ? (tl == PAUSE_TYPE_LEN || da == PAUSE_DA) // R6
                      : fc; // R7
    // the limit compare is strict: a frame of exactly the limit passes
    too_long = huge ? (len > HUGE_MAX_LEN) : (len > STD_MAX_LEN); // R12
    // bad frames pass only in debug mode, meant for use with mirroring
    frame_drop = pause_hit || too_long || (bad && !fwd_err); // R11
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register file and flush walker

  logic wr_gc0;
  logic wr_gc1;
  logic last_idx;
  logic hit;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.drop_v = 1'b0;
    wr_gc0 = reg_wr_i && reg_addr_i == GC_ZERO_OFS;
    wr_gc1 = reg_wr_i && reg_addr_i == GC_ONE_OFS;
    last_idx = st_r.idx == (st_r.cur_static ? STA_TBL_LAST : DYN_TBL_LAST);
    hit = ent_match(st_r.cur_static, ent_valid_i, ent_port_i,
                    ent_fwd_mask_i, ent_group_i, learn_dis_i);

    if (wr_gc0) begin
      st_nxt.alt_backoff = reg_wdata_i[GC0_ALT_BACKOFF_BIT]; // R1
      st_nxt.pause_mode = reg_wdata_i[GC0_PAUSE_MODE_BIT];
      st_nxt.link_age = reg_wdata_i[GC0_LINK_AGE_BIT];
    end
    // bits 5:4 of global control one live in another block and are not
    // held here; they read back as zero
    if (wr_gc1) begin
      st_nxt.fwd_err = reg_wdata_i[GC1_FWD_ERR_BIT];
      st_nxt.huge = reg_wdata_i[GC1_HUGE_BIT];
      st_nxt.gc1_low = reg_wdata_i[3:0];
    end

    // table walk: one read, one check, an optional delete per entry
    unique case (st_r.fst)
      FL_IDLE: begin
        if (st_r.dyn_pend) begin
          st_nxt.fst = FL_READ;
          st_nxt.cur_static = 1'b0;
          st_nxt.idx = '0;
        end else if (st_r.sta_pend) begin
          st_nxt.fst = FL_READ;
          st_nxt.cur_static = 1'b1;
          st_nxt.idx = '0;
        end
      end
      FL_READ: begin
        st_nxt.fst = FL_CHECK;
      end
      FL_CHECK, FL_DEL: begin
        if (st_r.fst == FL_CHECK && hit) begin
          st_nxt.fst = FL_DEL; // R3 R5
        end else if (last_idx) begin
          st_nxt.fst = FL_IDLE;
          if (st_r.cur_static) begin
            st_nxt.sta_pend = 1'b0; // R4 R13
          end else begin
            st_nxt.dyn_pend = 1'b0; // R2 R13
          end
        end else begin
          st_nxt.fst = FL_READ;
          st_nxt.idx = st_r.idx + 10'h001;
        end
      end
    endcase

    // a new trigger wins over the end of the walk; a trigger while the
    // same walk runs merges into it rather than restarting it
    if (wr_gc0 && reg_wdata_i[GC0_FLUSH_DYN_BIT]) begin
      st_nxt.dyn_pend = 1'b1; // R2
    end
    if (wr_gc0 && reg_wdata_i[GC0_FLUSH_STA_BIT]) begin
      st_nxt.sta_pend = 1'b1; // R4
    end

    // a read samples the registers as they stand before this edge, so a
    // write in the same cycle shows up on the next read only
    if (reg_rd_i) begin
      st_nxt.rvalid = 1'b1;
      // other offsets belong to neighbouring register blocks
      st_nxt.rdata = 8'h00;
      case (reg_addr_i)
        GC_ZERO_OFS: begin
          st_nxt.rdata[GC0_ALT_BACKOFF_BIT] = st_r.alt_backoff;
          st_nxt.rdata[GC0_RSVD6_BIT] = RSVD6_VAL;
          st_nxt.rdata[GC0_FLUSH_DYN_BIT] = st_r.dyn_pend; // R13
          st_nxt.rdata[GC0_FLUSH_STA_BIT] = st_r.sta_pend; // R13
          st_nxt.rdata[GC0_RSVD3_BIT] = RSVD32_VAL;
          st_nxt.rdata[GC0_RSVD2_BIT] = RSVD32_VAL;
          st_nxt.rdata[GC0_PAUSE_MODE_BIT] = st_r.pause_mode;
          st_nxt.rdata[GC0_LINK_AGE_BIT] = st_r.link_age;
        end
        GC_ONE_OFS: begin
          st_nxt.rdata[GC1_FWD_ERR_BIT] = st_r.fwd_err;
          st_nxt.rdata[GC1_HUGE_BIT] = st_r.huge;
          st_nxt.rdata[3:0] = st_r.gc1_low;
        end
        default: begin
          st_nxt.rdata = 8'h00;
        end
      endcase
    end

    if (frm_chk_i) begin
      st_nxt.drop_v = 1'b1;
      st_nxt.drop = frame_drop(st_r.pause_mode, st_r.fwd_err, st_r.huge,
                               frm_type_len_i, frm_da_i, frm_fc_i,
                               frm_bad_i, frm_len_i);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_r <= '0;
      st_r.alt_backoff <= RST_ALT_BACKOFF;
      st_r.pause_mode <= RST_PAUSE_MODE;
      st_r.link_age <= RST_LINK_AGE;
      st_r.fwd_err <= RST_FWD_ERR;
      st_r.huge <= RST_HUGE;
      st_r.gc1_low <= RST_GC1_LOW;
      st_r.fst <= FL_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata_o = st_r.rdata;
  assign reg_rvalid_o = st_r.rvalid;
  assign alt_backoff_o = st_r.alt_backoff; // R1
  assign pause_filter_mode_o = st_r.pause_mode;
  assign fwd_err_frames_o = st_r.fwd_err; // R11
  assign huge_frame_en_o = st_r.huge; // R12
  assign gc1_low_o = st_r.gc1_low;
  // walk strobes decode straight from the state so the table sees them in
  // the very cycle the index is presented
  assign tbl_rd_o = st_r.fst == FL_READ;
  assign tbl_del_o = st_r.fst == FL_DEL;
  assign tbl_static_o = st_r.cur_static;
  assign tbl_idx_o = st_r.idx;
  assign frm_drop_o = st_r.drop;
  assign frm_drop_v_o = st_r.drop_v;

  // link losses reach the timer only while the enable bit is set; the
  // timer itself keeps the edge history so no false fall follows reset
  swgc_age_timer #(
    .FAST_CYC(FAST_CYC),
    .NORM_CYC(NORM_CYC)
  ) u_age (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .link_age_en_i(st_r.link_age),
    .link_up_i(link_up_i),
    .age_pass_done_i(age_pass_done_i),
    .age_start_o(age_start_o),
    .fast_age_o(fast_age_o)
  );

endmodule

/* tb/swgc_regs_asserts.sv */
// concurrent checks on the global control register ports
`timescale 1ns/1ps
module swgc_regs_asserts
  import swgc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rvalid_o,
  input wire logic alt_backoff_o,
  input wire logic pause_filter_mode_o,
  input wire logic fwd_err_frames_o,
  input wire logic huge_frame_en_o,
  input wire logic tbl_rd_o,
  input wire logic tbl_del_o,
  input wire logic age_start_o,
  input wire logic fast_age_o,
  input wire logic frm_chk_i,
  input wire logic frm_drop_v_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  wire w0 = reg_wr_i && (reg_addr_i == GC_ZERO_OFS);
  wire w1 = reg_wr_i && (reg_addr_i == GC_ONE_OFS);
  ////////////////////////////////////////////////////////////////////////////
  property p_alt; w0 |=> alt_backoff_o == $past(reg_wdata_i[7]); endproperty
  a_alt: assert property (p_alt) else $error("alt backoff not written");
  property p_pause;
    w0 |=> pause_filter_mode_o == $past(reg_wdata_i[1]);
  endproperty
  a_pause: assert property (p_pause) else $error("pause mode bad");
  property p_fwd; w1 |=> fwd_err_frames_o == $past(reg_wdata_i[7]); endproperty
  a_fwd: assert property (p_fwd) else $error("fwd err bit bad");
  property p_huge; w1 |=> huge_frame_en_o == $past(reg_wdata_i[6]); endproperty
  a_huge: assert property (p_huge) else $error("huge bit bad");
  // mode outputs only move on a register write
  property p_hold;
    !reg_wr_i |=> $stable({alt_backoff_o, pause_filter_mode_o,
                           fwd_err_frames_o, huge_frame_en_o});
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed unwritten");
  property p_rv; reg_rd_i |=> reg_rvalid_o; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_del; tbl_del_o |-> $past(tbl_rd_o, 2) && !tbl_rd_o; endproperty
  a_del: assert property (p_del) else $error("delete without read");
  property p_age; age_start_o |=> !age_start_o; endproperty
  a_age: assert property (p_age) else $error("age start too long");
  property p_fast; $rose(fast_age_o) |-> age_start_o; endproperty
  a_fast: assert property (p_fast) else $error("fast pass not started");
  property p_frm; frm_chk_i |=> frm_drop_v_o; endproperty
  a_frm: assert property (p_frm) else $error("frame verdict missing");
  c_del: cover property (tbl_del_o);
  c_fast: cover property ($fell(fast_age_o));
  c_frm: cover property (frm_drop_v_o && pause_filter_mode_o);
endmodule
bind swgc_regs swgc_regs_asserts u_asserts (.clk_sys_i(clk_sys_i),
  .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rvalid_o(reg_rvalid_o), .alt_backoff_o(alt_backoff_o),
  .pause_filter_mode_o(pause_filter_mode_o),
  .fwd_err_frames_o(fwd_err_frames_o), .huge_frame_en_o(huge_frame_en_o),
  .tbl_rd_o(tbl_rd_o), .tbl_del_o(tbl_del_o), .age_start_o(age_start_o),
  .fast_age_o(fast_age_o), .frm_chk_i(frm_chk_i),
  .frm_drop_v_o(frm_drop_v_o));

/* tb/tb_swgc_regs.sv */
// self-checking bench for the global control registers
`timescale 1ns/1ps
module tb_swgc_regs;
  import swgc_pkg::*;
  logic clk_sys_i, srst_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, v;
  logic alt_backoff_o, pause_filter_mode_o, fwd_err_frames_o;
  logic huge_frame_en_o, tbl_rd_o, tbl_del_o, tbl_static_o;
  logic [3:0] gc1_low_o, learn_dis_i, link_up_i, ent_fwd_mask_i;
  logic [TBL_IDX_W-1:0] tbl_idx_o;
  logic ent_valid_i, ent_group_i, age_pass_done_i, age_start_o, fast_age_o;
  logic [1:0] ent_port_i;
  logic frm_chk_i, frm_fc_i, frm_bad_i, frm_drop_o, frm_drop_v_o;
  logic [15:0] frm_type_len_i;
  logic [47:0] frm_da_i;
  logic [11:0] frm_len_i;
  int n_fail = 0, tests_run = 0, ndyn = 0, nsta = 0, nage = 0, i;
  swgc_regs #(.FAST_CYC(36'h14), .NORM_CYC(36'h32)) DUT (.*);
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic final_report();
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1; reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 chk(16'(reg_rvalid_o), 16'h0001);
    d = reg_rdata_o;
  endtask
  task automatic frm(input logic [15:0] tl, input logic [47:0] da,
                     input logic fc, input logic bad, input logic [11:0] len,
                     input logic exp);
    @(posedge clk_sys_i);
    frm_chk_i <= 1'b1; frm_type_len_i <= tl; frm_da_i <= da;
    frm_fc_i <= fc; frm_bad_i <= bad; frm_len_i <= len;
    @(posedge clk_sys_i);
    frm_chk_i <= 1'b0;
    #1 chk(16'(frm_drop_v_o), 16'h0001);
    chk(16'(frm_drop_o), 16'(exp));
  endtask
  // table model: port from index, bit 2 multicast, bit 3 adds port 0 to the mask
  always @(posedge clk_sys_i) begin
    ent_valid_i <= 1'b1;
    ent_port_i <= tbl_idx_o[1:0];
    ent_group_i <= tbl_idx_o[2];
    ent_fwd_mask_i <= (4'h1 << tbl_idx_o[1:0]) | {3'h0, tbl_idx_o[3]};
    if (tbl_del_o && tbl_static_o) nsta++;
    if (tbl_del_o && !tbl_static_o) ndyn++;
    if (age_start_o) nage++;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst_i = 1'b1; reg_wr_i = 1'b0; reg_rd_i = 1'b0; reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00; learn_dis_i = 4'h2; link_up_i = 4'hF;
    age_pass_done_i = 1'b0; frm_chk_i = 1'b0; frm_fc_i = 1'b0;
    frm_bad_i = 1'b0; frm_type_len_i = 16'h0000; frm_da_i = 48'h0;
    frm_len_i = 12'h040;
    repeat (10) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    rd(8'h02, v); chk(16'(v), 16'h000C);
    rd(8'h03, v); chk(16'(v), 16'h0000);
    rd(8'h05, v); chk(16'(v), 16'h0000);
    wr(8'h02, 8'h83);
    wr(8'h03, 8'hFF);
    wr(8'h04, 8'hFF);
    rd(8'h02, v); chk(16'(v), 16'h008F);
    rd(8'h03, v); chk(16'(v), 16'h00CF);
    chk(16'({alt_backoff_o, pause_filter_mode_o}), 16'h0003);
    chk(16'({fwd_err_frames_o, huge_frame_en_o, gc1_low_o}), 16'h003F);
    frm(16'h8808, 48'h0, 1'b0, 1'b0, 12'h040, 1'b1);
    frm(16'h0800, PAUSE_DA, 1'b0, 1'b0, 12'h040, 1'b1);
    frm(16'h0800, 48'h0, 1'b1, 1'b0, 12'h040, 1'b0);
    frm(16'h0800, 48'h0, 1'b0, 1'b1, 12'h800, 1'b0);
    frm(16'h0800, 48'h0, 1'b0, 1'b0, 12'h801, 1'b1);
    wr(8'h03, 8'h00);
    wr(8'h02, 8'h01);
    frm(16'h8808, PAUSE_DA, 1'b0, 1'b0, 12'h040, 1'b0);
    frm(16'h0800, 48'h0, 1'b1, 1'b0, 12'h040, 1'b1);
    frm(16'h0800, 48'h0, 1'b0, 1'b1, 12'h040, 1'b1);
    frm(16'h0800, 48'h0, 1'b0, 1'b0, 12'h600, 1'b0);
    frm(16'h0800, 48'h0, 1'b0, 1'b0, 12'h601, 1'b1);
    // both flushes at once: dynamic walk then static walk
    wr(8'h02, 8'h31);
    rd(8'h02, v); chk(16'(v), 16'h003D);
    for (i = 0; i < 500 && v[5:4] != 2'b00; i++) begin
      repeat (10) @(posedge clk_sys_i);
      rd(8'h02, v);
    end
    chk(16'(v), 16'h000D);
    chk(16'(ndyn), 16'h0100);
    chk(16'(nsta), 16'h0002);
    @(posedge clk_sys_i) link_up_i <= 4'hB;
    repeat (3) @(posedge clk_sys_i);
    #1 chk(16'({age_start_o, fast_age_o}), 16'h0001);
    @(posedge clk_sys_i) age_pass_done_i <= 1'b1;
    @(posedge clk_sys_i) age_pass_done_i <= 1'b0;
    #1 chk(16'(fast_age_o), 16'h0000);
    nage = 0;
    repeat (120) @(posedge clk_sys_i);
    chk(16'(nage), 16'h0002);
    wr(8'h02, 8'h00);
    @(posedge clk_sys_i) link_up_i <= 4'h9;
    repeat (5) @(posedge clk_sys_i);
    #1 chk(16'(fast_age_o), 16'h0000);
    final_report();
  end
endmodule
